// ### logic/blge_core.sv
// executer of the 8-bit load group with a classic Wishbone register slave
// assumes a memory on clk_i that answers reads combinationally in the cycle of mem_rd_o
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`include "blge_consts.svh"
module blge_core import blge_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // memory bus
    output logic [15:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] gpr [0:7]; // slot 6 holds the flags, as field 110 never names a register
    logic [15:0] pc_reg, ix_reg, iy_reg, opnd_reg, addr_next, idx, eff_nn, rd_word;
    logic [7:0] vec_reg, rc_reg, b, eff_d, wdata_next, rc_inc;
    logic run_reg, ief1_reg, ief2_reg, bad_reg, ed_reg, ocnt_reg, bus_wr, start;
    logic [1:0] pfx_reg, nop_reg, d_nop;
    logic [2:0] dst_reg, src_reg, d_dst, d_src, src_sel;
    logic [4:0] t_reg, tot_reg, d_tot, t_next;
    blge_state_t st_reg, st_next;
    blge_kind_t kind_reg, d_kind;
    blge_asrc_t asrc_reg, d_asrc, asrc_sel;

    assign b = mem_rdata_i;
    assign start = (st_reg == ST_FETCH) && (t_reg == 5'h00);
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rc_inc = {rc_reg[7], rc_reg[6:0] + 7'h01};

    ////////////////////////////////////////////////////////////////////////////////
    // decode of the byte on the bus during a fetch
    always_comb begin
        d_kind = K_BAD;
        d_dst = b[5:3];
        d_src = b[2:0];
        d_asrc = A_HL;
        d_nop = 2'h0;
        d_tot = `BLGE_T_RR;
        if (ed_reg) begin
            if (b == `BLGE_OP_A_VEC || b == `BLGE_OP_A_RC || b == `BLGE_OP_VEC_A
                || b == `BLGE_OP_RC_A) begin
                d_kind = K_SPC;
                d_tot = `BLGE_T_SPC;
            end
        end else if (pfx_reg != 2'h0) begin
            if (b[7:6] == 2'h1 && ((b[2:0] == `BLGE_FLD_MEM) != (b[5:3] == `BLGE_FLD_MEM))) begin
                d_kind = (b[2:0] == `BLGE_FLD_MEM) ? K_RD : K_WR;
                d_asrc = A_IDX;
                d_nop = 2'h1;
                d_tot = `BLGE_T_IDX;
            end
        end else if (b == `BLGE_OP_PFX_X || b == `BLGE_OP_PFX_Y || b == `BLGE_OP_PFX_E) begin
            d_kind = K_PFX;
        end else if (b[7:6] == 2'h1) begin
            if (b[5:3] != `BLGE_FLD_MEM && b[2:0] != `BLGE_FLD_MEM) begin
                d_kind = K_RR;
            end else if (b[5:3] != `BLGE_FLD_MEM) begin
                d_kind = K_RD;
                d_tot = `BLGE_T_MEM;
            end else if (b[2:0] != `BLGE_FLD_MEM) begin
                d_kind = K_WR;
                d_tot = `BLGE_T_MEM;
            end
        end else if (b[7:6] == 2'h0 && b[2:0] == `BLGE_FLD_MEM && b[5:3] != `BLGE_FLD_MEM) begin
            d_kind = K_RN;
            d_nop = 2'h1;
            d_tot = `BLGE_T_MEM;
        end else begin
            d_dst = `BLGE_FLD_A;
            d_src = `BLGE_FLD_A;
            d_tot = `BLGE_T_MEM;
            case (b)
                `BLGE_OP_A_P1: begin d_kind = K_RD; d_asrc = A_BC; end
                `BLGE_OP_A_P2: begin d_kind = K_RD; d_asrc = A_DE; end
                `BLGE_OP_P1_A: begin d_kind = K_WR; d_asrc = A_BC; end
                `BLGE_OP_P2_A: begin d_kind = K_WR; d_asrc = A_DE; end
                `BLGE_OP_A_NN, `BLGE_OP_NN_A: begin
                    d_kind = (b == `BLGE_OP_A_NN) ? K_RD : K_WR;
                    d_asrc = A_NN;
                    d_nop = 2'h2;
                    d_tot = `BLGE_T_NN;
                end
                default: d_kind = K_BAD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // operand address: operands still on the bus are taken straight from it
    assign asrc_sel = (st_reg == ST_FETCH) ? d_asrc : asrc_reg;
    assign src_sel = (st_reg == ST_FETCH) ? d_src : src_reg;
    assign eff_nn = (st_reg == ST_OPND) ? {b, opnd_reg[7:0]} : opnd_reg;
    assign eff_d = (st_reg == ST_OPND) ? b : opnd_reg[7:0];
    assign idx = (pfx_reg == 2'h1) ? ix_reg : iy_reg;
    assign wdata_next = gpr[src_sel];

    always_comb begin
        case (asrc_sel)
            A_BC: addr_next = {gpr[0], gpr[1]};
            A_DE: addr_next = {gpr[2], gpr[3]};
            A_NN: addr_next = eff_nn;
            A_IDX: addr_next = idx + {{8{eff_d[7]}}, eff_d};
            default: addr_next = {gpr[4], gpr[5]};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer; every instruction lasts exactly tot T states from its first fetch
    always_comb begin
        st_next = ST_PAD;
        t_next = t_reg + 5'h01;
        case (st_reg)
            ST_IDLE: begin
                st_next = run_reg ? ST_FETCH : ST_IDLE;
                t_next = 5'h00;
            end
            ST_FETCH: begin
                if (d_kind == K_PFX) st_next = ST_FETCH;
                else if (d_kind == K_BAD) st_next = ST_IDLE;
                else if (d_nop != 2'h0) st_next = ST_OPND;
                else if (d_kind == K_RD) st_next = ST_RD;
                else if (d_kind == K_WR) st_next = ST_WR;
            end
            ST_OPND: begin
                if (!ocnt_reg && nop_reg == 2'h2) st_next = ST_OPND;
                else if (kind_reg == K_RD) st_next = ST_RD;
                else if (kind_reg == K_WR) st_next = ST_WR;
            end
            ST_PAD: begin
                if (t_reg == tot_reg - 5'h01) begin
                    st_next = run_reg ? ST_FETCH : ST_IDLE;
                    t_next = 5'h00;
                end
            end
            default: st_next = ST_PAD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= ST_IDLE;
            t_reg <= 5'h00;
            pfx_reg <= 2'h0;
            ed_reg <= 1'b0;
            ocnt_reg <= 1'b0;
            kind_reg <= K_BAD;
            dst_reg <= 3'h0;
            src_reg <= 3'h0;
            asrc_reg <= A_HL;
            nop_reg <= 2'h0;
            tot_reg <= `BLGE_T_RR;
        end else begin
            st_reg <= st_next;
            t_reg <= t_next;
            if (t_next == 5'h00) begin
                pfx_reg <= 2'h0;
                ed_reg <= 1'b0;
            end else if (st_reg == ST_FETCH && d_kind == K_PFX) begin
                pfx_reg <= (b == `BLGE_OP_PFX_X) ? 2'h1 : (b == `BLGE_OP_PFX_Y) ? 2'h2 : 2'h0;
                ed_reg <= (b == `BLGE_OP_PFX_E);
            end
            if (st_reg == ST_FETCH && d_kind != K_PFX) begin
                kind_reg <= d_kind;
                dst_reg <= d_dst;
                src_reg <= d_src;
                asrc_reg <= d_asrc;
                nop_reg <= d_nop;
                tot_reg <= d_tot;
            end
            ocnt_reg <= (st_reg == ST_OPND) && !ocnt_reg;
        end
    end

    // memory strobes registered for the cycle in which the state is active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_o <= `BLGE_RST_PC;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_wdata_o <= `BLGE_RST_BYTE;
        end else begin
            mem_rd_o <= (st_next == ST_FETCH) || (st_next == ST_OPND) || (st_next == ST_RD);
            mem_wr_o <= (st_next == ST_WR);
            mem_wdata_o <= wdata_next;
            if (st_next == ST_FETCH || st_next == ST_OPND) begin
                mem_addr_o <= (st_reg == ST_FETCH || st_reg == ST_OPND) ? pc_reg + 16'h0001 : pc_reg;
            end else begin
                mem_addr_o <= addr_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register word seen by the bus
    always_comb begin
        case (wb_adr_i)
            `BLGE_OFS_CTRL: rd_word = {11'h000, (st_reg != ST_IDLE), bad_reg, ief2_reg, ief1_reg,
                run_reg};
            `BLGE_OFS_PC: rd_word = pc_reg;
            `BLGE_OFS_VR: rd_word = {rc_reg, vec_reg};
            default: rd_word = 16'h0000;
        endcase
    end

    function automatic logic [31:0] merge(input logic [31:0] old);
        for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) old[i*8 +: 8] = wb_dat_i[i*8 +: 8];
        end
        return old;
    endfunction

    // lane-merged write words, so single bits can be picked out of them
    logic [31:0] ctrl_wr, pc_wr, vr_wr;
    assign ctrl_wr = merge(32'h0000_0000);
    assign pc_wr = merge({16'h0000, pc_reg});
    assign vr_wr = merge({16'h0000, rc_reg, vec_reg});

    // datapath; processor writes come last so they win over a bus write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) gpr[i] <= `BLGE_RST_BYTE;
            pc_reg <= `BLGE_RST_PC;
            ix_reg <= `BLGE_RST_PC;
            iy_reg <= `BLGE_RST_PC;
            opnd_reg <= `BLGE_RST_PC;
            vec_reg <= `BLGE_RST_BYTE;
            rc_reg <= `BLGE_RST_BYTE;
            {run_reg, ief1_reg, ief2_reg, bad_reg} <= 4'h0;
        end else begin
            if (bus_wr) begin
                case (wb_adr_i)
                    `BLGE_OFS_CTRL: begin
                        run_reg <= ctrl_wr[`BLGE_CTRL_RUN];
                        ief1_reg <= ctrl_wr[`BLGE_CTRL_IEF1];
                        ief2_reg <= ctrl_wr[`BLGE_CTRL_IEF2];
                        if (ctrl_wr[`BLGE_CTRL_BAD]) bad_reg <= 1'b0;
                    end
                    `BLGE_OFS_PC: pc_reg <= pc_wr[15:0];
                    `BLGE_OFS_BCDE: {gpr[0], gpr[1], gpr[2], gpr[3]} <=
                        merge({gpr[0], gpr[1], gpr[2], gpr[3]});
                    `BLGE_OFS_HLFA: {gpr[4], gpr[5], gpr[6], gpr[7]} <=
                        merge({gpr[4], gpr[5], gpr[6], gpr[7]});
                    `BLGE_OFS_VR: {rc_reg, vec_reg} <= vr_wr[15:0];
                    `BLGE_OFS_IDX: {iy_reg, ix_reg} <= merge({iy_reg, ix_reg});
                    default: ;
                endcase
            end
            if (st_reg == ST_FETCH || st_reg == ST_OPND) pc_reg <= pc_reg + 16'h0001;
            if (st_reg == ST_OPND) opnd_reg[ocnt_reg*8 +: 8] <= b;
            if (st_reg == ST_OPND && kind_reg == K_RN) gpr[dst_reg] <= b;
            if (st_reg == ST_RD) gpr[dst_reg] <= b;
            if (st_reg == ST_FETCH) begin
                rc_reg <= rc_inc;
                if (d_kind == K_BAD) begin
                    bad_reg <= 1'b1; // unknown opcodes halt, software sees it in control
                    run_reg <= 1'b0;
                end
                if (d_kind == K_RR) gpr[d_dst] <= gpr[d_src];
                if (d_kind == K_SPC) begin
                    case (b)
                        `BLGE_OP_VEC_A: vec_reg <= gpr[7];
                        `BLGE_OP_RC_A: rc_reg <= gpr[7];
                        default: begin
                            // the counter value read already includes this fetch
                            gpr[7] <= (b == `BLGE_OP_A_VEC) ? vec_reg : rc_inc;
                            gpr[6][`BLGE_FL_S] <= (b == `BLGE_OP_A_VEC) ? vec_reg[7] : rc_inc[7];
                            gpr[6][`BLGE_FL_Z] <= ((b == `BLGE_OP_A_VEC) ? vec_reg : rc_inc) == 8'h00;
                            gpr[6][`BLGE_FL_H] <= 1'b0;
                            gpr[6][`BLGE_FL_N] <= 1'b0;
                            gpr[6][`BLGE_FL_PV] <= ief2_reg;
                        end
                    endcase
                end
            end
        end
    end

    // wishbone answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            case (wb_adr_i)
                `BLGE_OFS_BCDE: wb_dat_o <= {gpr[0], gpr[1], gpr[2], gpr[3]};
                `BLGE_OFS_HLFA: wb_dat_o <= {gpr[4], gpr[5], gpr[6], gpr[7]};
                `BLGE_OFS_IDX: wb_dat_o <= {iy_reg, ix_reg};
                default: wb_dat_o <= {16'h0000, rd_word};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_field_copy: assert property (
        start && b == 8'h47 && pfx_reg == 2'h0 && !ed_reg |=> gpr[0] == $past(gpr[7]))
        else $error("register copy used the wrong field");
    chk_copy_four: assert property (
        start && d_kind == K_RR |-> ##4 (start || st_reg == ST_IDLE))
        else $error("register copy did not last 4 cycles");
    chk_imm_seven: assert property (
        start && d_kind == K_RN |-> ##1 mem_rd_o ##6 (start || st_reg == ST_IDLE))
        else $error("immediate load did not last 7 cycles");
    chk_ptr_load: assert property (
        start && d_kind == K_RD && d_asrc == A_HL
        |=> st_reg == ST_RD && mem_addr_o == {gpr[4], gpr[5]} ##6 (start || st_reg == ST_IDLE))
        else $error("pointer load address or timing wrong");
    chk_idx_access: assert property (
        (st_reg == ST_RD || st_reg == ST_WR) && pfx_reg != 2'h0
        |-> mem_addr_o == idx + {{8{opnd_reg[7]}}, opnd_reg[7:0]} && tot_reg == `BLGE_T_IDX
            ##16 (start || st_reg == ST_IDLE))
        else $error("indexed access address or timing wrong");
    chk_ptr_store: assert property (
        st_reg == ST_WR && asrc_reg == A_HL
        |-> mem_wr_o && mem_addr_o == {gpr[4], gpr[5]} && mem_wdata_o == gpr[src_reg])
        else $error("pointer store wrong");
    chk_acc_pair: assert property (
        start && b == `BLGE_OP_A_P1 && pfx_reg == 2'h0 && !ed_reg
        |=> mem_addr_o == {gpr[0], gpr[1]} ##1 gpr[7] == $past(mem_rdata_i))
        else $error("accumulator pair load wrong");
    chk_acc_direct: assert property (
        st_reg == ST_WR && asrc_reg == A_NN |-> mem_addr_o == opnd_reg && mem_wdata_o == gpr[7]
        && tot_reg == `BLGE_T_NN)
        else $error("direct accumulator store wrong");
    chk_vec_read: assert property (
        st_reg == ST_FETCH && ed_reg && b == `BLGE_OP_A_VEC
        |=> gpr[7] == $past(vec_reg) && !gpr[6][`BLGE_FL_H] && !gpr[6][`BLGE_FL_N]
            && gpr[6][`BLGE_FL_PV] == ief2_reg && $stable(ief1_reg) && $stable(ief2_reg))
        else $error("vector page read into accumulator wrong");
    chk_refresh_step: assert property (
        st_reg == ST_FETCH && !(ed_reg && b == `BLGE_OP_RC_A) && !bus_wr
        |=> rc_reg == {$past(rc_reg[7]), $past(rc_reg[6:0]) + 7'h01})
        else $error("refresh counter did not step");
    chk_flags_kept: assert property (
        !(st_reg == ST_FETCH && ed_reg) && !bus_wr |=> $stable(gpr[6]))
        else $error("flags changed by a plain load");
endmodule // blge_core

// ### logic/blge_consts.svh
// constants of the byte load group executer: bus offsets, bit positions, opcodes, timing
// assumes one T state equals one clk_i period
`ifndef BLGE_CONSTS_SVH
`define BLGE_CONSTS_SVH
// register offsets (byte addresses)
`define BLGE_OFS_CTRL 8'h00
`define BLGE_OFS_PC 8'h04
`define BLGE_OFS_BCDE 8'h08
`define BLGE_OFS_HLFA 8'h0C
`define BLGE_OFS_VR 8'h10
`define BLGE_OFS_IDX 8'h14
// control bits
`define BLGE_CTRL_RUN 0
`define BLGE_CTRL_IEF1 1
`define BLGE_CTRL_IEF2 2
`define BLGE_CTRL_BAD 3
`define BLGE_CTRL_BUSY 4
// flag bits
`define BLGE_FL_S 7
`define BLGE_FL_Z 6
`define BLGE_FL_H 4
`define BLGE_FL_PV 2
`define BLGE_FL_N 1
// register field codes
`define BLGE_FLD_MEM 3'h6
`define BLGE_FLD_A 3'h7
// opcodes
`define BLGE_OP_PFX_X 8'hDD
`define BLGE_OP_PFX_Y 8'hFD
`define BLGE_OP_PFX_E 8'hED
`define BLGE_OP_A_VEC 8'h57
`define BLGE_OP_A_RC 8'h5F
`define BLGE_OP_VEC_A 8'h47
`define BLGE_OP_RC_A 8'h4F
`define BLGE_OP_A_P1 8'h0A
`define BLGE_OP_A_P2 8'h1A
`define BLGE_OP_A_NN 8'h3A
`define BLGE_OP_P1_A 8'h02
`define BLGE_OP_P2_A 8'h12
`define BLGE_OP_NN_A 8'h32
// timing in T states, one T state per clock
`define BLGE_T_RR 5'h04
`define BLGE_T_MEM 5'h07
`define BLGE_T_SPC 5'h09
`define BLGE_T_NN 5'h0D
`define BLGE_T_IDX 5'h13
// reset values
`define BLGE_RST_BYTE 8'h00
`define BLGE_RST_PC 16'h0000
`endif

// ### logic/blge_pkg.sv
// types of the byte load group executer
// assumes blge_consts.svh carries the numbers
package blge_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_OPND, ST_RD, ST_WR, ST_PAD} blge_state_t;
    typedef enum logic [2:0] {K_PFX, K_RR, K_RN, K_RD, K_WR, K_SPC, K_BAD} blge_kind_t;
    typedef enum logic [2:0] {A_HL, A_BC, A_DE, A_NN, A_IDX} blge_asrc_t;
endpackage

// ### bench/blge_mem.sv
// memory partner for the byte load group executer: 64k bytes, no wait states
// assumes reads are answered in the same cycle as the read strobe
`timescale 1ns/1ns
module blge_mem (
    // clock
    input wire logic clk_i,
    // memory bus
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg = 8'hA5;
    // off strobe the bus shows the inverse of the last byte, so a late sample never matches
    assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last_reg;
    // plain always: the bench preloads the array directly
    always @(posedge clk_i) begin
        if (mem_rd_i) begin
            last_reg <= mem[mem_addr_i];
        end
        if (mem_wr_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
    end
endmodule // blge_mem

// ### bench/blge_core_bench.sv
// self-checking bench of the byte load group executer
// assumes blge_mem as the memory and a one-cycle-late wishbone ack
`timescale 1ns/1ns
`include "blge_consts.svh"
module blge_core_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, q;
    logic wb_ack_o, mem_rd_o, mem_wr_o;
    logic [15:0] mem_addr_o;
    logic [7:0] mem_wdata_o, mem_rdata_i, rn;
    logic [31:0] rq[$], wq[$];
    localparam logic [31:0] bc0 = 32'h11223344, hf0 = 32'h2010135A;
    int miscompares = 0, check_count = 0, cyc_n = 0, t0 = -1, t1 = -1, hlen = 1;
    integer seed = 32'hD0BD083A;

    always #50 clk_i = ~clk_i;

    blge_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
    blge_mem MEM (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
        .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5C;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one classic cycle; c set means the read result is queued for the monitor
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic c, input logic [31:0] e);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        if (c) begin
            rq.push_back(e);
        end
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // result monitor: read data, store traffic and instruction length
    always @(posedge clk_i) begin
        cyc_n++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
            chk(wb_dat_o, rq.pop_front());
        end
        if (mem_rd_o === 1'b1 && mem_addr_o === 16'h0100 && t0 < 0) begin
            t0 = cyc_n;
        end
        if (mem_rd_o === 1'b1 && mem_addr_o === 16'h0100 + hlen[15:0]) begin
            t1 = cyc_n;
        end
        if (mem_wr_o === 1'b1) begin
            chk({8'h00, mem_addr_o, mem_wdata_o}, wq.size() > 0 ? wq.pop_front() : 32'hFFFFFFFF);
        end
    end

    // run one instruction followed by an illegal byte that stops the core
    task automatic one(input logic [23:0] op, input int n, input int t, input logic [31:0] bcde,
                       input logic [31:0] hlfa, input logic [15:0] vr, input logic [24:0] w);
        int i;
        for (i = 0; i < n; i++) begin
            MEM.mem[16'h0100 + i] = op[23 - 8 * i -: 8];
        end
        MEM.mem[16'h0100 + n] = 8'h76;
        hlen = n;
        t0 = -1;
        t1 = -1;
        if (w[24]) begin
            wq.push_back({8'h00, w[23:0]});
        end
        wb(1'b1, `BLGE_OFS_BCDE, bc0, 1'b0, 32'h0);
        wb(1'b1, `BLGE_OFS_HLFA, hf0, 1'b0, 32'h0);
        wb(1'b1, `BLGE_OFS_VR, 32'h000000C3, 1'b0, 32'h0);
        wb(1'b1, `BLGE_OFS_IDX, 32'h21002200, 1'b0, 32'h0);
        wb(1'b1, `BLGE_OFS_PC, 32'h00000100, 1'b0, 32'h0);
        // run, second enable copy set, sticky illegal cleared
        wb(1'b1, `BLGE_OFS_CTRL, 32'h0000000D, 1'b0, 32'h0);
        i = 0;
        do begin
            wb(1'b0, `BLGE_OFS_CTRL, 32'h0, 1'b0, 32'h0);
            i++;
        end while ((q[4] | q[0]) !== 1'b0 && i < 30);
        if (i >= 30 || t1 < 0) begin
            miscompares++;
            tally_and_finish();
        end
        chk(32'(t1 - t0), 32'(t));
        wb(1'b0, `BLGE_OFS_CTRL, 32'h0, 1'b1, 32'h0000000C);
        wb(1'b0, `BLGE_OFS_PC, 32'h0, 1'b1, 32'(32'h101 + n));
        wb(1'b0, `BLGE_OFS_BCDE, 32'h0, 1'b1, bcde);
        wb(1'b0, `BLGE_OFS_HLFA, 32'h0, 1'b1, hlfa);
        wb(1'b0, `BLGE_OFS_VR, 32'h0, 1'b1, {16'h0000, vr});
        chk(32'(wq.size()), 32'h0);
        $display("test %h done", op);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int a = 0; a < 65536; a++) begin
            MEM.mem[a] = pat(a[15:0]);
        end
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `BLGE_OFS_CTRL, 32'h0, 1'b1, 32'h0);
        wb(1'b0, `BLGE_OFS_HLFA, 32'h0, 1'b1, 32'h0);
        wb(1'b0, 8'h40, 32'h0, 1'b1, 32'h0);
        rn = 8'($random(seed));
        one(24'h780000, 1, 4, bc0, 32'h20101311, 16'h02C3, 25'h0);
        one(24'h410000, 1, 4, 32'h22223344, hf0, 16'h02C3, 25'h0);
        one(24'h470000, 1, 4, 32'h5A223344, hf0, 16'h02C3, 25'h0);
        one(24'h5C0000, 1, 4, 32'h11223320, hf0, 16'h02C3, 25'h0);
        one(24'h620000, 1, 4, bc0, 32'h3310135A, 16'h02C3, 25'h0);
        one(24'h6F0000, 1, 4, bc0, 32'h205A135A, 16'h02C3, 25'h0);
        one({8'h3E, rn, 8'h00}, 2, 7, bc0, {24'h201013, rn}, 16'h02C3, 25'h0);
        one(24'h7E0000, 1, 7, bc0, {24'h201013, pat(16'h2010)}, 16'h02C3, 25'h0);
        one(24'hDD7EFD, 3, 19, bc0, {24'h201013, pat(16'h21FD)}, 16'h03C3, 25'h0);
        one(24'hFD4605, 3, 19, {pat(16'h2105), 24'h223344}, hf0, 16'h03C3, 25'h0);
        one(24'h0A0000, 1, 7, bc0, {24'h201013, pat(16'h1122)}, 16'h02C3, 25'h0);
        one(24'h1A0000, 1, 7, bc0, {24'h201013, pat(16'h3344)}, 16'h02C3, 25'h0);
        one(24'h3A0030, 3, 13, bc0, {24'h201013, pat(16'h3000)}, 16'h02C3, 25'h0);
        one(24'hED5700, 2, 9, bc0, 32'h201085C3, 16'h03C3, 25'h0);
        one(24'hED5F00, 2, 9, bc0, 32'h20100502, 16'h03C3, 25'h0);
        one(24'hED4700, 2, 9, bc0, hf0, 16'h035A, 25'h0);
        one(24'hED4F00, 2, 9, bc0, hf0, 16'h5BC3, 25'h0);
        one(24'h710000, 1, 7, bc0, hf0, 16'h02C3, {1'b1, 16'h2010, 8'h22});
        one(24'hDD707F, 3, 19, bc0, hf0, 16'h03C3, {1'b1, 16'h227F, 8'h11});
        one(24'h020000, 1, 7, bc0, hf0, 16'h02C3, {1'b1, 16'h1122, 8'h5A});
        one(24'h120000, 1, 7, bc0, hf0, 16'h02C3, {1'b1, 16'h3344, 8'h5A});
        one(24'h323412, 3, 13, bc0, hf0, 16'h02C3, {1'b1, 16'h1234, 8'h5A});
        tally_and_finish();
    end
endmodule // blge_core_bench
